/* design/ashp_port.sv */
`timescale 1ns/1ns
// ==================================================
// Notes on behaviour
// - first four input bits form the command
// - strobe start: bit 15 on first fall
// - select start: bit 15 on first fall
// - later input bits sampled on falling edges
// - ignore input after 16 edges or deselect
// - shift edges counted only while selected
// - output released while deselected, driven after select
// - output word sent top bit first
// - strobe start: top bit before first fall
// - select start: top bit before first fall
// - later output bits change on rising edges
// - select/convert frames return previous result
// - frame after a queue read returns the popped queue word
// - output released on sixteenth falling edge
// - output released while converting in modes 1-3
// - strobe low at select: strobe fall starts frame
module ashp_port
	import ashp_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        sclk,
	input  wire logic        chipSelectN,
	input  wire logic        frame_start_strobe,
	input  wire logic        serial_in_line,
	input  wire logic [13:0] resultData,
	input  wire logic [13:0] queueData,
	input  wire logic        converting,
	input  wire logic [1:0]  convMode,
	output logic             serial_out_line,
	output logic             serialOutEnable,
	output ashp_cmd_t        commandOut,
	output logic             queuePop,
	output logic             convClockTick
);

	// ==================================================
	// pin synchronisers
	ashp_pins_t rawPins;
	ashp_pins_t pins;
	assign rawPins = '{sclk: sclk, chipSelectN: chipSelectN,
		frameStart: frame_start_strobe, serialIn: serial_in_line};

	ashp_sync u_sync (
		.sys_clk (sys_clk),
		.reset   (reset),
		.pinsIn  (rawPins),
		.pinsOut (pins)
	);

	// ==================================================
	// edge detect on synchronised copies
	ashp_pins_t  prevPins;
	logic        sclkRise;
	logic        sclkFall;
	logic        csFall;
	logic        csRise;
	logic        fsRise;
	logic        fsFall;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prevPins <= 4'h6;
		end else begin
			prevPins <= pins;
		end
	end

	always_comb begin
		sclkRise = pins.sclk & ~prevPins.sclk;
		sclkFall = ~pins.sclk & prevPins.sclk;
		csFall   = ~pins.chipSelectN & prevPins.chipSelectN;
		csRise   = pins.chipSelectN & ~prevPins.chipSelectN;
		fsRise   = pins.frameStart & ~prevPins.frameStart;
		fsFall   = ~pins.frameStart & prevPins.frameStart;
	end

	// ==================================================
	// frame state
	ashp_state_t state;
	ashp_state_t next_state;
	logic [4:0]  edgeCount;
	logic [4:0]  next_edgeCount;
	logic [15:0] inShift;
	logic [15:0] next_inShift;
	logic [15:0] outShift;
	logic [15:0] next_outShift;
	logic        strobeMode;
	logic        next_strobeMode;
	logic        driveOut;
	logic        next_driveOut;
	logic        outBit;
	logic        next_outBit;
	ashp_cmd_t   next_commandOut;
	logic        next_queuePop;
	logic        next_convTick;
	logic        lastQueueRead;
	logic        next_lastQueueRead;
	logic [13:0] queueWord;
	logic [13:0] next_queueWord;
	logic        quietConv;

	function automatic logic [15:0] load_word(input logic [13:0] word);
		load_word = {word, 2'h0};
	endfunction

	// modes other than 00 float the line while converting
	assign quietConv = converting & (convMode != MODE_00);

	always_comb begin
		next_state         = state;
		next_edgeCount     = edgeCount;
		next_inShift       = inShift;
		next_outShift      = outShift;
		next_strobeMode    = strobeMode;
		next_driveOut      = driveOut;
		next_outBit        = outBit;
		next_commandOut    = commandOut;
		next_commandOut.valid = 1'b0;
		next_queuePop      = 1'b0;
		next_lastQueueRead = lastQueueRead;
		next_queueWord     = queueWord;
		// deselected clock still serves as conversion clock
		next_convTick      = sclkFall & pins.chipSelectN;
		case (state)
			ASHP_IDLE: begin
				if (csFall) begin
					next_edgeCount  = EDGE_ZERO;
					next_strobeMode = ~pins.frameStart;
					next_outShift   = lastQueueRead ? load_word(queueWord)
						: load_word(resultData);
					next_driveOut   = 1'b1;
					next_outBit     = next_outShift[CMD_TOP];
					next_state      = pins.frameStart ? ASHP_SHIFT : ASHP_ARMED;
				end
			end
			ASHP_ARMED: begin
				if (fsRise) begin
					next_edgeCount = EDGE_ZERO;
				end
				if (fsFall && strobeMode) begin
					// next falling clock takes bit 15
					next_edgeCount = EDGE_ZERO;
					next_outBit    = outShift[CMD_TOP];
					next_state     = ASHP_SHIFT;
				end
			end
			ASHP_SHIFT: begin
				if (sclkFall) begin
					next_inShift   = {inShift[14:0], pins.serialIn};
					next_edgeCount = edgeCount + 5'h01;
					if (edgeCount + 5'h01 == LAST_EDGE) begin
						next_driveOut = 1'b0;
						next_commandOut.valid       = 1'b1;
						next_commandOut.command     = next_inShift[15:12];
						next_commandOut.config_data = next_inShift[11:0];
						next_lastQueueRead = (next_inShift[15:12] == CMD_QUEUE_READ);
						next_queuePop = (next_inShift[15:12] == CMD_QUEUE_READ);
						// popped word kept, head may move on before the next frame
						next_queueWord = queueData;
						next_state     = ASHP_DONE;
					end
				end else if (sclkRise && edgeCount != EDGE_ZERO) begin
					next_outShift = {outShift[14:0], 1'b0};
					next_outBit   = outShift[14];
				end
			end
			ASHP_DONE: begin
				next_driveOut = 1'b0;
			end
			default: next_state = ASHP_IDLE;
		endcase
		if (csRise) begin
			next_driveOut = 1'b0;
			next_state    = ASHP_IDLE;
		end
		if (pins.chipSelectN) begin
			next_driveOut = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state         <= ASHP_IDLE;
			edgeCount     <= EDGE_ZERO;
			inShift       <= 16'h0000;
			outShift      <= 16'h0000;
			strobeMode    <= 1'b0;
			driveOut      <= 1'b0;
			outBit        <= 1'b0;
			commandOut    <= '0;
			queuePop      <= 1'b0;
			lastQueueRead <= 1'b0;
			queueWord     <= 14'h0000;
			convClockTick <= 1'b0;
		end else begin
			state         <= next_state;
			edgeCount     <= next_edgeCount;
			inShift       <= next_inShift;
			outShift      <= next_outShift;
			strobeMode    <= next_strobeMode;
			driveOut      <= next_driveOut;
			outBit        <= next_outBit;
			commandOut    <= next_commandOut;
			queuePop      <= next_queuePop;
			lastQueueRead <= next_lastQueueRead;
			queueWord     <= next_queueWord;
			convClockTick <= next_convTick;
		end
	end

	// ==================================================
	// pin drivers, registered
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			serial_out_line <= 1'b0;
			serialOutEnable <= 1'b0;
		end else begin
			serial_out_line <= next_outBit;
			serialOutEnable <= next_driveOut & ~quietConv;
		end
	end

	// ==================================================
	// checks
	a_hiz_deselect: assert property (@(posedge sys_clk) disable iff (reset)
		pins.chipSelectN |=> !serialOutEnable)
		else $error("output driven while deselected");

	a_edge_limit: assert property (@(posedge sys_clk) disable iff (reset)
		edgeCount <= LAST_EDGE)
		else $error("edge counter past sixteen");

	a_release_last: assert property (@(posedge sys_clk) disable iff (reset)
		(state == ASHP_SHIFT && sclkFall && edgeCount == 5'h0F) |=> ##1 !serialOutEnable)
		else $error("output not released on last edge");

	a_cmd_capture: assert property (@(posedge sys_clk) disable iff (reset)
		commandOut.valid |-> commandOut.command == inShift[15:12])
		else $error("command field mismatch");

	a_select_clear: assert property (@(posedge sys_clk) disable iff (reset)
		(state == ASHP_IDLE && csFall) |=> edgeCount == EDGE_ZERO)
		else $error("counter not cleared on select");

	a_top_first: assert property (@(posedge sys_clk) disable iff (reset)
		(state == ASHP_IDLE && csFall) |=> ##1 serial_out_line == outShift[15])
		else $error("top bit not presented first");

	a_rise_shift: assert property (@(posedge sys_clk) disable iff (reset)
		(state == ASHP_SHIFT && sclkRise && edgeCount != EDGE_ZERO && !csRise)
		|=> outBit == $past(outShift[14]))
		else $error("output bit not advanced on rise");

	a_quiet_conv: assert property (@(posedge sys_clk) disable iff (reset)
		quietConv |=> !serialOutEnable)
		else $error("output driven during conversion");

	a_fall_sample: assert property (@(posedge sys_clk) disable iff (reset)
		(state == ASHP_SHIFT && sclkFall && !csRise)
		|=> inShift[0] == $past(pins.serialIn))
		else $error("input not sampled on fall");

endmodule

/* design/ashp_pkg.sv */
package ashp_pkg;

	// ==================================================
	// frame geometry
	localparam int FRAME_BITS   = 16;
	localparam int CMD_BITS     = 4;
	localparam int CFG_BITS     = 12;
	localparam int RESULT_BITS  = 14;
	localparam int CMD_TOP      = 15;
	localparam int CMD_LOW      = 12;
	localparam logic [4:0] LAST_EDGE = 5'h10;
	localparam logic [4:0] EDGE_ZERO = 5'h00;

	// ==================================================
	// command codes (plain defaults)
	localparam logic [3:0] CMD_CONFIG_LOAD = 4'hA;
	localparam logic [3:0] CMD_QUEUE_READ  = 4'hE;
	localparam logic [3:0] CMD_IDLE        = 4'h0;

	// ==================================================
	// conversion modes
	localparam logic [1:0] MODE_00 = 2'h0;

	typedef enum {ASHP_IDLE, ASHP_ARMED, ASHP_SHIFT, ASHP_DONE} ashp_state_t;

	// command captured at end of frame
	typedef struct packed {
		logic        valid;
		logic [3:0]  command;
		logic [11:0] config_data;
	} ashp_cmd_t;

	// pin group as seen from the device
	typedef struct packed {
		logic sclk;
		logic chipSelectN;
		logic frameStart;
		logic serialIn;
	} ashp_pins_t;

endpackage

/* design/ashp_sync.sv */
`timescale 1ns/1ns
module ashp_sync
	import ashp_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire ashp_pins_t pinsIn,
	output ashp_pins_t      pinsOut
);

	// ==================================================
	// two-stage synchroniser; first stage read only by second
	ashp_pins_t stage1;
	ashp_pins_t next_stage1;
	ashp_pins_t next_pinsOut;

	always_comb begin
		next_stage1  = pinsIn;
		next_pinsOut = stage1;
	end

	// idle bus: clock low, selects and strobe high
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stage1  <= 4'h6;
			pinsOut <= 4'h6;
		end else begin
			stage1  <= next_stage1;
			pinsOut <= next_pinsOut;
		end
	end

endmodule

/* testbench/ashp_host.sv */
`timescale 1ns/1ns
// ==================================================
// host serial port model, link clock runs inside frames and, in pulses, while deselected
module ashp_host (
	output logic           sclk,
	output logic           chipSelectN,
	output logic           frameStart,
	output logic           serialIn,
	input  wire logic      serialOut,
	input  wire logic      serialOutEnable,
	output logic           enSeen,
	output logic           enLate
);
	initial begin
		sclk = 1'b0;
		chipSelectN = 1'b1;
		frameStart = 1'b1;
		serialIn = 1'b1;
		enSeen = 1'b0;
		enLate = 1'b0;
	end

	task automatic frame(input logic [15:0] din, input logic useStrobe, output logic [15:0] dout);
		enSeen = 1'b0;
		if (useStrobe) begin
			frameStart = 1'b0;
		end
		#64 chipSelectN = 1'b0;
		if (useStrobe) begin
			#64 frameStart = 1'b1;
			#64 frameStart = 1'b0;
		end
		#64;
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b1;
			serialIn = din[i];
			#32 sclk = 1'b0;
			dout[i] = serialOut;
			enSeen = enSeen | serialOutEnable;
			#32;
		end
		// select held low a while so the release is the device's own
		#8 enLate = serialOutEnable;
		chipSelectN = 1'b1;
		frameStart = 1'b1;
		serialIn = 1'b1;
		#64;
	endtask

	// frame cut short: select rises after n clock pulses
	task automatic cut(input int n);
		#64 chipSelectN = 1'b0;
		#64;
		repeat (n) begin
			sclk = 1'b1;
			#32 sclk = 1'b0;
			#32;
		end
		chipSelectN = 1'b1;
		#64;
	endtask

	task automatic pulses(input int n);
		repeat (n) begin
			#32 sclk = 1'b1;
			#32 sclk = 1'b0;
		end
		#64;
	endtask
endmodule

/* testbench/ashp_port_tb.sv */
`timescale 1ns/1ns
module ashp_port_tb;
	import ashp_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [13:0] resultData = 14'h0000;
	logic [13:0] queueData = 14'h0000;
	logic        converting = 1'b0;
	logic [1:0]  convMode = MODE_00;
	logic        sclk, chipSelectN, frameStart, serialIn;
	logic        serialOut, serialOutEnable, queuePop, convClockTick, enSeen, enLate;
	ashp_cmd_t   commandOut;
	ashp_cmd_t   lastCmd = '0;
	logic [15:0] rx;
	int          n_errors = 0;
	int          checked = 0;
	int          pops = 0;
	int          ticks = 0;

	always #2 sys_clk = ~sys_clk;

	ashp_port dut (.sys_clk(sys_clk), .reset(reset), .sclk(sclk), .chipSelectN(chipSelectN),
		.frame_start_strobe(frameStart), .serial_in_line(serialIn),
		.resultData(resultData), .queueData(queueData), .converting(converting),
		.convMode(convMode), .serial_out_line(serialOut), .serialOutEnable(serialOutEnable),
		.commandOut(commandOut), .queuePop(queuePop), .convClockTick(convClockTick));

	ashp_host host (.sclk(sclk), .chipSelectN(chipSelectN), .frameStart(frameStart),
		.serialIn(serialIn), .serialOut(serialOut), .serialOutEnable(serialOutEnable),
		.enSeen(enSeen), .enLate(enLate));

	always @(posedge sys_clk) begin
		if (queuePop === 1'b1) pops++;
		if (convClockTick === 1'b1) ticks++;
		if (commandOut.valid === 1'b1) lastCmd <= commandOut;
	end

	// ==================================================
	// shared helpers
	task automatic check(input logic [16:0] got, input logic [16:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// stale command cleared first, so a missing capture cannot pass
	task automatic run(input logic [15:0] din, input logic useStrobe);
		@(posedge sys_clk);
		lastCmd <= '0;
		#1 host.frame(din, useStrobe, rx);
	endtask

	task automatic final_report();
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ==================================================
	// scenarios
	task automatic t_select();
		@(posedge sys_clk) resultData <= 14'h2A5C;
		run(16'h0000, 1'b0);
		check(rx[15:2], 14'h2A5C);
		check(enSeen, 1'b1);
		check(enLate, 1'b0);
		check(lastCmd, {1'b1, CMD_IDLE, 12'h000});
		$display("test select done");
	endtask

	task automatic t_strobe();
		@(posedge sys_clk) resultData <= 14'h1337;
		run(16'h5000, 1'b1);
		check(rx[15:2], 14'h1337);
		check(lastCmd, {1'b1, 4'h5, 12'h000});
		$display("test strobe done");
	endtask

	task automatic t_config();
		run({CMD_CONFIG_LOAD, 12'hC3A}, 1'b0);
		check(lastCmd, {1'b1, CMD_CONFIG_LOAD, 12'hC3A});
		$display("test config done");
	endtask

	task automatic t_queue();
		int p0;
		p0 = pops;
		@(posedge sys_clk) queueData <= 14'h3E01;
		run({CMD_QUEUE_READ, 12'h000}, 1'b0);
		check(pops - p0, 1);
		// head moves on after the pop; the popped word must still come out
		@(posedge sys_clk) queueData <= 14'h0155;
		run(16'h0000, 1'b0);
		check(rx[15:2], 14'h3E01);
		$display("test queue done");
	endtask

	task automatic t_conv();
		for (int m = 0; m < 4; m++) begin
			@(posedge sys_clk);
			converting <= 1'b1;
			convMode <= 2'(m);
			run(16'h0000, 1'b0);
			check(enSeen, m == 0);
			if (m == 0) check(rx[15:2], 14'h1337);
		end
		@(posedge sys_clk);
		converting <= 1'b0;
		convMode <= MODE_00;
		$display("test conv done");
	endtask

	// a cut frame must not capture, and must not skew the next frame's count
	task automatic t_cut();
		@(posedge sys_clk);
		lastCmd <= '0;
		#1 host.cut(8);
		check(lastCmd, 17'h00000);
		check(serialOutEnable, 1'b0);
		run({CMD_CONFIG_LOAD, 12'h5A5}, 1'b0);
		check(lastCmd, {1'b1, CMD_CONFIG_LOAD, 12'h5A5});
		check(rx[15:2], 14'h1337);
		$display("test cut done");
	endtask

	task automatic t_tick();
		int t0;
		t0 = ticks;
		host.pulses(5);
		check(ticks - t0, 5);
		check(serialOutEnable, 1'b0);
		$display("test tick done");
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (3) @(posedge sys_clk);
		check(serialOutEnable, 1'b0);
		t_select();
		t_strobe();
		t_config();
		t_queue();
		t_conv();
		t_cut();
		t_tick();
		final_report();
	end

	// ten frames of about 1.2 us each, generous margin
	initial begin
		#100000;
		n_errors++;
		final_report();
	end
endmodule
